//--- crt_cfg.svh
// named constants for the capture/reload timer: offsets, bit positions,
// reset values and prescale counts; included by the package only.
`ifndef CRT_CFG_SVH
`define CRT_CFG_SVH

// register indices on the plain register port
`define CRT_ADDR_W 3
`define CRT_DATA_W 8
`define CRT_OFS_CTRL 3'h0
`define CRT_OFS_MODE 3'h1
`define CRT_OFS_CNT_LO 3'h2
`define CRT_OFS_CNT_HI 3'h3
`define CRT_OFS_CAP_LO 3'h4
`define CRT_OFS_CAP_HI 3'h5

// timer_control bit positions
`define CRT_BIT_OVF 7
`define CRT_BIT_EXF 6
`define CRT_BIT_RXSEL 5
`define CRT_BIT_TXSEL 4
`define CRT_BIT_EXEN 3
`define CRT_BIT_RUN 2
`define CRT_BIT_SRC 1
`define CRT_BIT_CPRL 0

// mode_register bit position
`define CRT_BIT_DOWN_COUNT_ENABLE 0

// reset values
`define CRT_CTRL_RST 8'h00
`define CRT_DOWN_COUNT_ENABLE_RST 1'h0
`define CRT_CNT_RST 16'h0000
`define CRT_CAP_RST 16'h0000
`define CRT_RD_RST 8'h00

// counter limits
`define CRT_CNT_W 16
`define CRT_CNT_MAX 16'hFFFF
`define CRT_CNT_ONE 16'h0001
`define CRT_CNT_ZERO 16'h0000

// prescaler: machine cycle is twelve oscillator clocks, state time two
`define CRT_PRE_W 4
`define CRT_PRE_RST 4'h0
`define CRT_PRE_LAST 4'hB
`define CRT_PRE_ONE 4'h1
`define CRT_PRE_STATE_BIT 0

// pin synchroniser lanes
`define CRT_SYNC_N 2
`define CRT_LANE_CNT 0
`define CRT_LANE_TRIG 1

`endif

//--- crt_pkg.sv
// types shared by the capture/reload timer files.
// assumes crt_cfg.svh is on the include path.
package crt_pkg;
  `include "crt_cfg.svh"

  // gray sequence reload -> capture -> baud
  typedef enum logic [1:0] {
    CRT_MODE_RELOAD = 2'h0,
    CRT_MODE_CAPTURE = 2'h1,
    CRT_MODE_BAUD = 2'h3
  } crt_mode_t;

  // timer_control layout, msb first
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic ext_edge_enable;
    logic run_control;
    logic count_source_select;
    logic capture_reload_select;
  } crt_ctrl_t;

  typedef struct packed {
    logic [`CRT_ADDR_W-1:0] addr;
    logic [`CRT_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } crt_bus_req_t;
endpackage

//--- crt_sync.sv
// two-flop synchronisers for the timer pins, with falling-edge pulses.
// assumes pins are asynchronous to ref_clk_i and change slowly vs it.
`timescale 1ns/1ps
`default_nettype none
module crt_sync
  import crt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [`CRT_SYNC_N-1:0] pin_i,
  output logic [`CRT_SYNC_N-1:0] lvl_o,
  output logic [`CRT_SYNC_N-1:0] fall_o
);
  logic [`CRT_SYNC_N-1:0] meta_ff;
  logic [`CRT_SYNC_N-1:0] sync_ff;
  logic [`CRT_SYNC_N-1:0] prev_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `CRT_SYNC_N; gi++)
    begin : g_lane
      // pins idle high, so reset to one avoids a false edge
      always_ff @(posedge ref_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
        begin
          meta_ff[gi] <= 1'h1;
          sync_ff[gi] <= 1'h1;
          prev_ff[gi] <= 1'h1;
        end
        else if (ce_i)
        begin
          meta_ff[gi] <= pin_i[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
      assign fall_o[gi] = ce_i & prev_ff[gi] & ~sync_ff[gi];
    end
  endgenerate

  assign lvl_o = sync_ff;
endmodule
`default_nettype wire

//--- crt_timer.sv
// 16-bit capture / auto-reload / baud-rate timer with its register port.
// assumes one 200 MHz clock as oscillator, pins asynchronous, the other
// timer's overflow pulse on the same clock, and a one-cycle strobe bus.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module crt_timer
  import crt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire crt_pkg::crt_bus_req_t bus_i,
  output logic [`CRT_DATA_W-1:0] rd_data_o,
  input wire logic count_input_pin_i,
  input wire logic trigger_pin_i,
  input wire logic timer1_ovf_i,
  input wire logic timer_irq_en_i,
  output logic timer_irq_o,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o
);
  import crt_pkg::*;

  crt_ctrl_t ctrl_ff;
  crt_ctrl_t nxt_ctrl;
  logic down_count_enable_ff;
  logic nxt_down_count_enable;
  logic [`CRT_CNT_W-1:0] cnt_ff;
  logic [`CRT_CNT_W-1:0] nxt_cnt;
  logic [`CRT_CNT_W-1:0] cap_ff;
  logic [`CRT_CNT_W-1:0] nxt_cap;
  logic [`CRT_PRE_W-1:0] pre_ff;
  logic [`CRT_PRE_W-1:0] nxt_pre;
  logic [`CRT_DATA_W-1:0] rd_ff;
  logic [`CRT_DATA_W-1:0] nxt_rd;
  logic rx_tick_ff;
  logic tx_tick_ff;

  // pin synchronisation
  logic [`CRT_SYNC_N-1:0] pin_lvl;
  logic [`CRT_SYNC_N-1:0] pin_fall;

  crt_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .pin_i({trigger_pin_i, count_input_pin_i}),
    .lvl_o(pin_lvl),
    .fall_o(pin_fall)
  );

  wire trig_lvl = pin_lvl[`CRT_LANE_TRIG];
  wire trig_fall = pin_fall[`CRT_LANE_TRIG];
  wire cnt_pin_fall = pin_fall[`CRT_LANE_CNT];

  // register port decode
  wire acc_wr = ce_i & bus_i.wr;
  wire acc_rd = ce_i & bus_i.rd;
  wire wr_ctrl = acc_wr & (bus_i.addr == `CRT_OFS_CTRL);
  wire wr_mode = acc_wr & (bus_i.addr == `CRT_OFS_MODE);
  wire wr_cnt_lo = acc_wr & (bus_i.addr == `CRT_OFS_CNT_LO);
  wire wr_cnt_hi = acc_wr & (bus_i.addr == `CRT_OFS_CNT_HI);
  wire wr_cap_lo = acc_wr & (bus_i.addr == `CRT_OFS_CAP_LO);
  wire wr_cap_hi = acc_wr & (bus_i.addr == `CRT_OFS_CAP_HI);
  wire wr_cnt = wr_cnt_lo | wr_cnt_hi;
  wire [`CRT_DATA_W-1:0] wd = bus_i.wdata;

  // mode selection
  wire baud_sel = ctrl_ff.rx_clock_select | ctrl_ff.tx_clock_select;
  crt_mode_t mode;
  assign mode = baud_sel ? CRT_MODE_BAUD :
                (ctrl_ff.capture_reload_select ? CRT_MODE_CAPTURE :
                 CRT_MODE_RELOAD);

  logic is_cap;
  logic is_reload;
  logic is_baud;
  always_comb
  begin
    is_cap = 1'h0;
    is_reload = 1'h0;
    is_baud = 1'h0;
    case (mode)
      CRT_MODE_RELOAD: is_reload = 1'h1;
      CRT_MODE_CAPTURE: is_cap = 1'h1;
      CRT_MODE_BAUD: is_baud = 1'h1;
      default: is_reload = 1'h1;
    endcase
  end

  // direction from the trigger level only in up/down reload mode
  wire updown = is_reload & down_count_enable_ff;
  wire count_down = updown & ~trig_lvl;

  // prescaler: machine cycle and state time ticks
  wire pre_last = (pre_ff == `CRT_PRE_LAST);
  assign nxt_pre = pre_last ? `CRT_PRE_RST : pre_ff + `CRT_PRE_ONE;
  wire mc_tick = pre_last;
  wire st_tick = pre_ff[`CRT_PRE_STATE_BIT];

  // count source
  wire int_tick = is_baud ? st_tick : mc_tick;
  wire src_tick = ctrl_ff.count_source_select ? cnt_pin_fall : int_tick;
  wire inc = ctrl_ff.run_control & src_tick;

  // wrap detection
  wire at_max = (cnt_ff == `CRT_CNT_MAX);
  wire ovf = inc & ~count_down & at_max;
  wire unf = inc & count_down & (cnt_ff == cap_ff);
  wire wrap = ovf | unf;

  // trigger events; in up/down mode the pin is direction, not an event
  wire ext_ev = ctrl_ff.ext_edge_enable & trig_fall & ~updown;
  wire do_capture = is_cap & ext_ev;
  wire ext_reload = is_reload & ext_ev;
  wire ovf_set = wrap & ~is_baud;
  wire exf_toggle = updown & wrap;

  // counter next value; software write wins, low byte lane first
  logic [`CRT_CNT_W-1:0] hw_cnt;
  always_comb
  begin
    hw_cnt = cnt_ff;
    if (ext_reload)
      hw_cnt = cap_ff;
    else if (unf)
      hw_cnt = `CRT_CNT_MAX;
    else if (ovf && !is_cap)
      hw_cnt = cap_ff;
    else if (inc && count_down)
      hw_cnt = cnt_ff - `CRT_CNT_ONE;
    else if (inc)
      hw_cnt = cnt_ff + `CRT_CNT_ONE;
  end

  assign nxt_cnt = wr_cnt_lo ? {cnt_ff[`CRT_CNT_W-1:`CRT_DATA_W], wd} :
                   wr_cnt_hi ? {wd, cnt_ff[`CRT_DATA_W-1:0]} : hw_cnt;

  // capture registers; a capture beats a software write in the same cycle
  assign nxt_cap = do_capture ? cnt_ff :
                   wr_cap_lo ? {cap_ff[`CRT_CNT_W-1:`CRT_DATA_W], wd} :
                   wr_cap_hi ? {wd, cap_ff[`CRT_DATA_W-1:0]} : cap_ff;

  // control register; hardware set beats software clear
  wire sw_ovf = wr_ctrl ? wd[`CRT_BIT_OVF] : ctrl_ff.overflow_flag;
  wire sw_exf = wr_ctrl ? wd[`CRT_BIT_EXF] : ctrl_ff.external_flag;
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl)
      nxt_ctrl = crt_ctrl_t'(wd);
    nxt_ctrl.overflow_flag = sw_ovf | ovf_set;
    if (exf_toggle)
      nxt_ctrl.external_flag = ~ctrl_ff.external_flag;
    else
      nxt_ctrl.external_flag = sw_exf | ext_ev;
  end

  assign nxt_down_count_enable = wr_mode ? wd[`CRT_BIT_DOWN_COUNT_ENABLE] : down_count_enable_ff;

  // read mux, unmapped indices read zero
  logic [`CRT_DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = `CRT_RD_RST;
    case (bus_i.addr)
      `CRT_OFS_CTRL: rd_mux = ctrl_ff;
      `CRT_OFS_MODE: rd_mux = {{(`CRT_DATA_W-1){1'h0}}, down_count_enable_ff};
      `CRT_OFS_CNT_LO: rd_mux = cnt_ff[`CRT_DATA_W-1:0];
      `CRT_OFS_CNT_HI: rd_mux = cnt_ff[`CRT_CNT_W-1:`CRT_DATA_W];
      `CRT_OFS_CAP_LO: rd_mux = cap_ff[`CRT_DATA_W-1:0];
      `CRT_OFS_CAP_HI: rd_mux = cap_ff[`CRT_CNT_W-1:`CRT_DATA_W];
      default: rd_mux = `CRT_RD_RST;
    endcase
  end
  // data only valid the cycle after a read; otherwise zero
  assign nxt_rd = acc_rd ? rd_mux : `CRT_RD_RST;

  // serial clock routing
  wire my_ovf = is_baud & ovf;
  wire nxt_rx = ctrl_ff.rx_clock_select ? my_ovf : timer1_ovf_i;
  wire nxt_tx = ctrl_ff.tx_clock_select ? my_ovf : timer1_ovf_i;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl_ff <= crt_ctrl_t'(`CRT_CTRL_RST);
      down_count_enable_ff <= `CRT_DOWN_COUNT_ENABLE_RST;
      cnt_ff <= `CRT_CNT_RST;
      cap_ff <= `CRT_CAP_RST;
      pre_ff <= `CRT_PRE_RST;
    end
    else if (ce_i)
    begin
      ctrl_ff <= nxt_ctrl;
      down_count_enable_ff <= nxt_down_count_enable;
      cnt_ff <= nxt_cnt;
      cap_ff <= nxt_cap;
      pre_ff <= nxt_pre;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rd_ff <= `CRT_RD_RST;
      rx_tick_ff <= 1'h0;
      tx_tick_ff <= 1'h0;
    end
    else if (ce_i)
    begin
      rd_ff <= nxt_rd;
      rx_tick_ff <= nxt_rx;
      tx_tick_ff <= nxt_tx;
    end
  end

  // request follows flags directly so a clear drops it at once
  assign timer_irq_o = timer_irq_en_i &
                       (ctrl_ff.overflow_flag | (ctrl_ff.external_flag & ~updown));
  assign rd_data_o = rd_ff;
  assign rx_baud_tick_o = rx_tick_ff;
  assign tx_baud_tick_o = tx_tick_ff;

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_ovf_sets_flag: assert property (
    (ce_i && ovf && !is_baud) |=> ctrl_ff.overflow_flag)
    else $error("overflow did not set overflow flag");

  a_capture_copy: assert property (
    (ce_i && do_capture) |=> (cap_ff == $past(cnt_ff)))
    else $error("capture registers missed count value");

  a_capture_counts: assert property (
    (ce_i && is_cap && inc && !wr_cnt) |=> (cnt_ff == $past(cnt_ff) + `CRT_CNT_ONE))
    else $error("capture mode count did not advance by one");

  a_up_reload: assert property (
    (ce_i && ovf && !is_cap && !ext_reload && !wr_cnt) |=> (cnt_ff == $past(cap_ff)))
    else $error("overflow did not reload from capture registers");

  a_down_underflow: assert property (
    (ce_i && unf && !ext_reload && !wr_cnt) |=> (cnt_ff == `CRT_CNT_MAX))
    else $error("underflow did not load all ones");

  a_exf_toggles: assert property (
    (ce_i && exf_toggle) |=> (ctrl_ff.external_flag != $past(ctrl_ff.external_flag)))
    else $error("external flag did not toggle on wrap");

  a_updown_noirq: assert property (
    (updown && !ctrl_ff.overflow_flag) |-> !timer_irq_o)
    else $error("external flag raised interrupt in up/down mode");

  a_stop_holds: assert property (
    (ce_i && !ctrl_ff.run_control && !wr_cnt && !ext_reload) |=> $stable(cnt_ff))
    else $error("counter moved while stopped");

  a_baud_noflag: assert property (
    (ce_i && is_baud && !ctrl_ff.overflow_flag && !wr_ctrl) |=> !ctrl_ff.overflow_flag)
    else $error("baud mode set overflow flag");

  a_rx_route: assert property (
    (ce_i && ctrl_ff.rx_clock_select && ovf) |=> rx_baud_tick_o)
    else $error("receive tick missing after overflow");

  a_flag_sticky: assert property (
    (ce_i && ctrl_ff.overflow_flag && !wr_ctrl) |=> ctrl_ff.overflow_flag)
    else $error("overflow flag cleared without write");

  a_read_next: assert property (
    (ce_i && bus_i.rd && (bus_i.addr == `CRT_OFS_MODE)) |=> (rd_data_o == {7'h00, $past(down_count_enable_ff)}))
    else $error("mode register read back wrong");

  a_edge_reload: assert property (
    (ce_i && ext_reload && !wr_cnt) |=> (cnt_ff == $past(cap_ff)))
    else $error("trigger fall did not reload count");

  a_exf_set: assert property (
    (ce_i && ext_ev) |=> ctrl_ff.external_flag)
    else $error("trigger fall did not set external flag");

  a_edge_gate: assert property (
    (ce_i && !ctrl_ff.ext_edge_enable && !wr_cap_lo && !wr_cap_hi) |=> $stable(cap_ff))
    else $error("capture registers moved with edge enable clear");

  a_baud_hold: assert property (
    (ce_i && is_baud && !inc && !wr_cnt) |=> $stable(cnt_ff))
    else $error("baud mode count moved without a step");

  a_baud_step: assert property (
    (ce_i && is_baud && ctrl_ff.run_control && !ctrl_ff.count_source_select && !at_max
     && !wr_cnt && !wr_ctrl) ##1 (ce_i && !wr_cnt) |=> (cnt_ff != $past(cnt_ff, 2)))
    else $error("baud mode count slower than state time");

  a_tx_route: assert property (
    (ce_i && ctrl_ff.tx_clock_select && ovf) |=> tx_baud_tick_o)
    else $error("transmit tick missing after overflow");

  a_rx_other: assert property (
    (ce_i && !ctrl_ff.rx_clock_select) |=> (rx_baud_tick_o == $past(timer1_ovf_i)))
    else $error("receive tick not taken from other timer");

  a_mode_write: assert property (
    (ce_i && wr_mode) |=> (down_count_enable_ff == $past(bus_i.wdata[`CRT_BIT_DOWN_COUNT_ENABLE])))
    else $error("down count enable write lost");

  a_exf_sticky: assert property (
    (ce_i && ctrl_ff.external_flag && !wr_ctrl && !exf_toggle) |=> ctrl_ff.external_flag)
    else $error("external flag cleared without write");

  a_sw_clear: assert property (
    (ce_i && wr_ctrl && !bus_i.wdata[`CRT_BIT_OVF] && !ovf_set) |=> !ctrl_ff.overflow_flag)
    else $error("software clear of overflow flag lost");

  a_cap_hold: assert property (
    (ce_i && is_cap && !inc && !wr_cnt) |=> $stable(cnt_ff))
    else $error("capture mode count reloaded");
endmodule
`default_nettype wire

//--- HANDOVER_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- crt_pins.sv
// model of the external count and trigger pins of the timer.
// assumes one clock; pulses are held well beyond the two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module crt_pins
(
  input wire logic ref_clk_i,
  output logic count_pin_o,
  output logic trig_pin_o
);
  initial
  begin
    count_pin_o = 1'b1;
    trig_pin_o = 1'b1;
  end
  // low phase of four clocks and high phase of five, wider than the synchroniser
  task automatic pulse_count(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_i) count_pin_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      count_pin_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
    end
  endtask
  task automatic set_trig(input logic v);
    @(posedge ref_clk_i) trig_pin_o <= v;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the capture/reload timer over its register port.
// assumes crt_pkg compiled first; the pin model drives both timer pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crt_pkg::*;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  crt_bus_req_t bus = '0;
  logic [7:0] rd_data;
  logic cnt_pin, trig_pin, t1_ovf = 1'b0, irq_en = 1'b0, irq, rx_tick, tx_tick;
  logic ce = 1'b1;
  int error_cnt = 0;
  int n_tests = 0;
  logic [7:0] r;
  int n;
  logic [7:0] n_sel [2] = '{8'h14, 8'h24};
  always #2.5 ref_clk_i = ~ref_clk_i;
  crt_pins i_crt_pins (.ref_clk_i(ref_clk_i), .count_pin_o(cnt_pin), .trig_pin_o(trig_pin));
  crt_timer i_crt_timer (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
    .bus_i(bus), .rd_data_o(rd_data), .count_input_pin_i(cnt_pin),
    .trigger_pin_i(trig_pin), .timer1_ovf_i(t1_ovf), .timer_irq_en_i(irq_en),
    .timer_irq_o(irq), .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i) bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i) bus <= '0;
    #1 d = rd_data;
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 3'h1, v[15:8]);
  endtask
  task automatic chk16(input string name, input logic [2:0] a, input logic [15:0] e);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 3'h1, hi);
    check(name, {hi, lo}, e);
  endtask
  task automatic chk8(input string name, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check(name, {8'h00, v}, {8'h00, e});
  endtask
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++)
    begin
      rd(a[2:0], r);
      check("reset value", {8'h00, r}, 16'h0000);
    end
    wr(3'h7, 8'hA5);
    chk8("unmapped", 3'h7, 8'h00);
    // counter, capture mode: wrap sets overflow flag and interrupt
    wr16(3'h2, 16'hFFFE);
    wr(3'h0, 8'h07);
    i_crt_pins.pulse_count(2);
    chk16("wrap count", 3'h2, 16'h0000);
    chk8("ovf set", 3'h0, 8'h87);
    check("irq off", {15'h0, irq}, 16'h0000);
    @(posedge ref_clk_i) irq_en <= 1'b1;
    #10 check("irq on", {15'h0, irq}, 16'h0001);
    // capture on trigger fall, counting continues
    wr(3'h0, 8'h0F);
    chk8("ovf cleared", 3'h0, 8'h0F);
    i_crt_pins.pulse_count(3);
    i_crt_pins.set_trig(1'b0);
    i_crt_pins.set_trig(1'b1);
    chk16("captured", 3'h4, 16'h0003);
    chk8("exf set", 3'h0, 8'h4F);
    check("irq exf", {15'h0, irq}, 16'h0001);
    i_crt_pins.pulse_count(1);
    chk16("no reload", 3'h2, 16'h0004);
    // up-only auto-reload
    wr(3'h0, 8'h06);
    wr16(3'h4, 16'h1234);
    wr16(3'h2, 16'hFFFF);
    i_crt_pins.pulse_count(1);
    chk16("reload ovf", 3'h2, 16'h1234);
    chk8("reload flag", 3'h0, 8'h86);
    wr(3'h0, 8'h0E);
    wr16(3'h2, 16'h0050);
    i_crt_pins.set_trig(1'b0);
    i_crt_pins.set_trig(1'b1);
    chk16("reload edge", 3'h2, 16'h1234);
    chk8("edge flag", 3'h0, 8'h4E);
    wr(3'h0, 8'h06);
    wr16(3'h2, 16'h0050);
    i_crt_pins.set_trig(1'b0);
    i_crt_pins.set_trig(1'b1);
    chk16("edge ignored", 3'h2, 16'h0050);
    chk8("no flag", 3'h0, 8'h06);
    // up/down: exf toggles as seventeenth bit, no interrupt from it
    wr(3'h1, 8'h01);
    wr16(3'h2, 16'hFFFF);
    i_crt_pins.pulse_count(1);
    chk16("updown up", 3'h2, 16'h1234);
    chk8("exf toggle", 3'h0, 8'hC6);
    wr(3'h0, 8'h46);
    #10 check("exf no irq", {15'h0, irq}, 16'h0000);
    i_crt_pins.set_trig(1'b0);
    wr16(3'h2, 16'h1235);
    i_crt_pins.pulse_count(1);
    chk16("down step", 3'h2, 16'h1234);
    i_crt_pins.pulse_count(1);
    chk16("underflow", 3'h2, 16'hFFFF);
    chk8("exf back", 3'h0, 8'h86);
    i_crt_pins.set_trig(1'b1);
    irq_en <= 1'b0;
    // stopped counter ignores pin
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h02);
    wr16(3'h2, 16'h0010);
    i_crt_pins.pulse_count(2);
    chk16("stopped", 3'h2, 16'h0010);
    // internal timer: one step per twelve clocks
    wr16(3'h2, 16'h0000);
    wr(3'h0, 8'h05);
    rd(3'h2, r);
    repeat (118) @(posedge ref_clk_i);
    chk8("machine cycle", 3'h2, r + 8'h0A);
    // clock enable low freezes prescaler and counter: twelve live edges, one step
    rd(3'h2, r);
    @(posedge ref_clk_i) ce <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
    ce <= 1'b1;
    repeat (9) @(posedge ref_clk_i);
    chk8("ce freeze", 3'h2, r + 8'h01);
    // baud mode on either select: rollover every two state times, no flag
    // stop first so the count sits at the reload value when baud starts
    wr(3'h0, 8'h00);
    wr16(3'h4, 16'hFFFE);
    wr16(3'h2, 16'hFFFE);
    foreach (n_sel[i])
    begin
      wr(3'h0, n_sel[i]);
      n = 0;
      repeat (40)
      begin
        @(posedge ref_clk_i);
        #1 if ((i == 0 ? tx_tick : rx_tick) === 1'b1) n++;
      end
      check("baud ticks", n[15:0], 16'h000A);
      chk8("baud no ovf", 3'h0, n_sel[i]);
    end
    @(posedge ref_clk_i) t1_ovf <= 1'b1;
    @(posedge ref_clk_i) t1_ovf <= 1'b0;
    #1 check("tx from other", {15'h0, tx_tick}, 16'h0001);
    wr(3'h0, 8'h14);
    @(posedge ref_clk_i) t1_ovf <= 1'b1;
    @(posedge ref_clk_i) t1_ovf <= 1'b0;
    #1 check("rx from other", {15'h0, rx_tick}, 16'h0001);
    wr(3'h0, 8'h1C);
    i_crt_pins.set_trig(1'b0);
    i_crt_pins.set_trig(1'b1);
    chk8("baud exf", 3'h0, 8'h5C);
    final_report();
  end
endmodule
`default_nettype wire
